// >>> dfa_pkg.sv
// dfa_pkg: constants and types shared by the diagnostic fault aggregator files
// assumes: compiled before every other file of the block
//
// How it works
// - both die temperature comparators always active; nothing can disable them
// - two-bit trip select in setup one picks one of four temperature limits
// - die over-limit sets its sticky analog flag and pulls alarm low unless masked
// - supply comparators off after reset, enabled only by setup-two monitor bits
// - reference input comparator counts only while converter internal enable is set
// - each of four monitored nodes has its own window flag
// - reference output fault sets its flag; dependent flags may also follow
// - analog flags sticky, write one clears, reappear at once if fault persists
// - alarm is active-low open drain, released when no enabled fault
// - alarm mirror bit reads one while alarm output is driven low
// - per-source mask stops maskable faults; the mask has no effect on unmaskable sources
// - calibration-unrefreshed and reset-detected flags never drive the alarm
// - link, parity, checksum, power, supply faults always alarm; clock count alarms unless quiet bit set
// - oscillator, watchdog, latch, inverse, access, slip, checksum, output and temperature faults maskable
// - serial clock count error excluded from alarm while quiet bit set
// - diagnostic converter gives 12-bit result; mode and input from setup fields
// - five-bit input select map with reserved codes 00010 and 00101 to 01011
// - digital and analog summaries are live ORs; slew busy excluded
package dfa_pkg;
  // digital flag positions
  localparam int DG_OSC_STOP   = 0;
  localparam int DG_CAL_UNREF  = 1;
  localparam int DG_RESET_SEEN = 2;
  localparam int DG_LINK       = 3;
  localparam int DG_WDT        = 4;
  localparam int DG_PARITY     = 5;
  localparam int DG_LATCH      = 6;
  localparam int DG_INVERSE    = 7;
  localparam int DG_CAL_CRC    = 8;
  localparam int DG_ACCESS     = 9;
  localparam int DG_SCLK_CNT   = 10;
  localparam int DG_SLIP       = 11;
  localparam int DG_SER_CRC    = 12;
  localparam int DG_SLEW_BUSY  = 13;
  localparam int DG_W          = 14;
  // analog flag positions
  localparam int AN_OVERV      = 0;
  localparam int AN_DC_SHORT   = 1;
  localparam int AN_DC_POWER   = 2;
  localparam int AN_OPEN       = 3;
  localparam int AN_SHORT      = 4;
  localparam int AN_TEMP_DC    = 5;
  localparam int AN_TEMP_MAIN  = 6;
  localparam int AN_REF_OUT    = 7;
  localparam int AN_REF_IN     = 8;
  localparam int AN_RAIL       = 9;
  localparam int AN_REG        = 10;
  localparam int AN_W          = 11;
  // supply monitor enable bit positions in setup two
  localparam int MON_REF_IN    = 0;
  localparam int MON_REF_OUT   = 1;
  localparam int MON_REG       = 2;
  localparam int MON_RAIL      = 3;
  localparam int MON_W         = 4;
  // trip limits, degrees C, select 00..11 highest to lowest
  localparam int TRIP_142      = 142;
  localparam int TRIP_127      = 127;
  localparam int TRIP_112      = 112;
  localparam int TRIP_97       = 97;
  localparam int TEMP_W        = 9;
  // reset values
  localparam logic [DG_W-1:0] DG_RESET_VAL = 14'h0004;
  localparam logic [AN_W-1:0] AN_RESET_VAL = 11'h000;
  localparam int SYNC_STAGES   = 2;
  localparam int RESULT_W      = 12;
  localparam int SEL_W         = 5;
  localparam int MODE_W        = 3;
  // converter modes
  typedef enum logic [MODE_W-1:0] {
    DFA_MODE_IDLE    = 3'h0,
    DFA_MODE_KEY_SEQ = 3'h2,
    DFA_MODE_AUTO    = 3'h3,
    DFA_MODE_NOW     = 3'h4,
    DFA_MODE_KEY_ONE = 3'h5
  } dfa_mode_e;
  // input select codes
  localparam logic [SEL_W-1:0] SEL_TEMP_MAIN = 5'h00;
  localparam logic [SEL_W-1:0] SEL_TEMP_DC   = 5'h01;
  localparam logic [SEL_W-1:0] SEL_RSV_A     = 5'h02;
  localparam logic [SEL_W-1:0] SEL_REF_IN    = 5'h03;
  localparam logic [SEL_W-1:0] SEL_BANDGAP   = 5'h04;
  localparam logic [SEL_W-1:0] SEL_RSV_B     = 5'h05;
  localparam logic [SEL_W-1:0] SEL_RSV_C     = 5'h06;
  localparam logic [SEL_W-1:0] SEL_AUX_TWO   = 5'h0C;
  localparam logic [SEL_W-1:0] SEL_SENSE_P   = 5'h0D;
  localparam logic [SEL_W-1:0] SEL_SENSE_N   = 5'h0E;
  localparam logic [SEL_W-1:0] SEL_AUX1_LO   = 5'h0F;
  localparam logic [SEL_W-1:0] SEL_AUX1_HI   = 5'h12;
  localparam int CONV_CYCLES   = 16;
  localparam int CNT_W         = 5;
  typedef enum logic [1:0] {
    DFA_ST_IDLE,
    DFA_ST_CONV,
    DFA_ST_DONE
  } dfa_conv_e;
endpackage

// >>> dfa_sync_if.sv
// dfa_sync_if: raw comparator levels in, synchronised levels out
// assumes: one clock domain, the top module's I_CLK
`timescale 1ns/100ps
interface dfa_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// >>> dfa_sync.sv
// dfa_sync: two-flop synchroniser bank for asynchronous comparator levels
// assumes: raw levels may change at any time relative to i_clk
`timescale 1ns/100ps
module dfa_sync #(
  parameter int W = 1
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  dfa_sync_if.snk   port
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // first stage read only by second stage
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= port.raw;
      sync_q <= meta_q;
    end
  end
  assign port.synced = sync_q;
endmodule

// >>> dfa_top.sv
// dfa_top: sticky diagnostic flags, alarm merge, mirror, summaries, monitor converter
// assumes: comparator and fault levels are asynchronous; host clears by one-cycle pulses
`timescale 1ns/100ps
module dfa_top #(
  parameter int RES_W = dfa_pkg::RESULT_W
) (
  input  wire logic                    I_CLK,
  input  wire logic                    I_RESETN,
  // die temperature readings and comparator levels from the analog side
  input  wire logic [dfa_pkg::TEMP_W-1:0] I_TEMP_MAIN,
  input  wire logic [dfa_pkg::TEMP_W-1:0] I_TEMP_DC,
  input  wire logic [1:0]              I_TRIP_SEL,
  input  wire logic [dfa_pkg::MON_W-1:0] I_MON_EN,
  input  wire logic                    I_INT_EN,
  input  wire logic                    I_CMP_REF_IN,
  input  wire logic                    I_CMP_REF_OUT,
  input  wire logic                    I_CMP_REG,
  input  wire logic                    I_CMP_RAIL,
  input  wire logic [dfa_pkg::DG_W-1:0] I_DIG_FAULT,
  input  wire logic [4:0]              I_ANA_FAULT,
  input  wire logic [dfa_pkg::DG_W-1:0] I_DIG_CLR,
  input  wire logic [dfa_pkg::AN_W-1:0] I_ANA_CLR,
  input  wire logic [dfa_pkg::DG_W-1:0] I_DIG_MASK,
  input  wire logic [dfa_pkg::AN_W-1:0] I_ANA_MASK,
  input  wire logic                    I_QUIET,
  input  wire logic [dfa_pkg::MODE_W-1:0] I_CONV_MODE,
  input  wire logic [dfa_pkg::SEL_W-1:0]  I_CONV_SEL,
  input  wire logic                    I_CONV_KEY,
  input  wire logic [RES_W-1:0]        I_CONV_SAMPLE,
  output logic                         O_ALARM_N_OUT,
  output logic                         O_ALARM_N_OE_N,
  output logic                         O_ALARM_MIRROR,
  output logic [dfa_pkg::DG_W-1:0]     O_DIG_FLAGS,
  output logic [dfa_pkg::AN_W-1:0]     O_ANA_FLAGS,
  output logic                         O_DIG_SUMMARY,
  output logic                         O_ANA_SUMMARY,
  output logic                         O_WDT_SUMMARY,
  output logic [dfa_pkg::SEL_W-1:0]    O_MUX_SEL,
  output logic                         O_MUX_RESERVED,
  output logic [RES_W-1:0]             O_CONV_RESULT,
  output logic                         O_CONV_DONE
);
  localparam int RAW_W = dfa_pkg::DG_W + 5 + 4;

  // mask of sources that the mask register may gate
  localparam logic [dfa_pkg::DG_W-1:0] DG_MASKABLE =
    (14'h0001 << dfa_pkg::DG_OSC_STOP) | (14'h0001 << dfa_pkg::DG_WDT) |
    (14'h0001 << dfa_pkg::DG_LATCH) | (14'h0001 << dfa_pkg::DG_INVERSE) |
    (14'h0001 << dfa_pkg::DG_ACCESS) | (14'h0001 << dfa_pkg::DG_SLIP) |
    (14'h0001 << dfa_pkg::DG_SER_CRC);
  localparam logic [dfa_pkg::DG_W-1:0] DG_NO_ALARM =
    (14'h0001 << dfa_pkg::DG_CAL_UNREF) | (14'h0001 << dfa_pkg::DG_RESET_SEEN) |
    (14'h0001 << dfa_pkg::DG_SLEW_BUSY);
  localparam logic [dfa_pkg::AN_W-1:0] AN_MASKABLE =
    (11'h001 << dfa_pkg::AN_OVERV) | (11'h001 << dfa_pkg::AN_DC_SHORT) |
    (11'h001 << dfa_pkg::AN_OPEN) | (11'h001 << dfa_pkg::AN_SHORT) |
    (11'h001 << dfa_pkg::AN_TEMP_DC) | (11'h001 << dfa_pkg::AN_TEMP_MAIN);

  // trip limit lookup, select 0 is the highest limit
  function automatic logic [dfa_pkg::TEMP_W-1:0] trip_limit(input logic [1:0] sel);
    logic [dfa_pkg::TEMP_W-1:0] lim;
    lim = '0;
    unique case (sel)
      2'h0: lim = dfa_pkg::TEMP_W'(dfa_pkg::TRIP_142);
      2'h1: lim = dfa_pkg::TEMP_W'(dfa_pkg::TRIP_127);
      2'h2: lim = dfa_pkg::TEMP_W'(dfa_pkg::TRIP_112);
      2'h3: lim = dfa_pkg::TEMP_W'(dfa_pkg::TRIP_97);
    endcase
    return lim;
  endfunction

  // reserved select codes
  function automatic logic sel_reserved(input logic [dfa_pkg::SEL_W-1:0] s);
    return (s == dfa_pkg::SEL_RSV_A) || (s == dfa_pkg::SEL_RSV_B) ||
           (s == dfa_pkg::SEL_RSV_C) ||
           ((s > dfa_pkg::SEL_BANDGAP) && (s < dfa_pkg::SEL_AUX_TWO));
  endfunction

  // sticky update: set wins over clear, clear re-reads live fault
  function automatic logic [dfa_pkg::DG_W-1:0] sticky(
    input logic [dfa_pkg::DG_W-1:0] cur,
    input logic [dfa_pkg::DG_W-1:0] live,
    input logic [dfa_pkg::DG_W-1:0] clr);
    return (cur & ~clr) | live;
  endfunction

  // synchroniser for all asynchronous levels
  dfa_sync_if #(.W(RAW_W)) sync_bus ();
  assign sync_bus.raw = {I_DIG_FAULT, I_ANA_FAULT, I_CMP_REF_IN, I_CMP_REF_OUT, I_CMP_REG, I_CMP_RAIL};
  dfa_sync #(.W(RAW_W)) u_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .port     (sync_bus.snk)
  );
  logic [dfa_pkg::DG_W-1:0] dig_live;
  logic [4:0]               ana_out_live;
  logic                     cmp_ref_in;
  logic                     cmp_ref_out;
  logic                     cmp_reg;
  logic                     cmp_rail;
  assign {dig_live, ana_out_live, cmp_ref_in, cmp_ref_out, cmp_reg, cmp_rail} = sync_bus.synced;

  // temperature readings sampled twice before comparison
  logic [dfa_pkg::TEMP_W-1:0] tm_meta_q;
  logic [dfa_pkg::TEMP_W-1:0] tm_q;
  logic [dfa_pkg::TEMP_W-1:0] td_meta_q;
  logic [dfa_pkg::TEMP_W-1:0] td_q;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tm_meta_q <= '0;
      tm_q      <= '0;
      td_meta_q <= '0;
      td_q      <= '0;
    end else begin
      tm_meta_q <= I_TEMP_MAIN;
      tm_q      <= tm_meta_q;
      td_meta_q <= I_TEMP_DC;
      td_q      <= td_meta_q;
    end
  end

  // live analog faults; temperature compare has no enable at all
  logic [dfa_pkg::AN_W-1:0] ana_live;
  always_comb begin
    ana_live = '0;
    ana_live[dfa_pkg::AN_OVERV]     = ana_out_live[0];
    ana_live[dfa_pkg::AN_DC_SHORT]  = ana_out_live[1];
    ana_live[dfa_pkg::AN_DC_POWER]  = ana_out_live[2];
    ana_live[dfa_pkg::AN_OPEN]      = ana_out_live[3];
    ana_live[dfa_pkg::AN_SHORT]     = ana_out_live[4];
    ana_live[dfa_pkg::AN_TEMP_MAIN] = tm_q > trip_limit(I_TRIP_SEL);
    ana_live[dfa_pkg::AN_TEMP_DC]   = td_q > trip_limit(I_TRIP_SEL);
    // window comparators gated by monitor enables
    ana_live[dfa_pkg::AN_REF_IN]  = cmp_ref_in & I_MON_EN[dfa_pkg::MON_REF_IN] & I_INT_EN;
    ana_live[dfa_pkg::AN_REF_OUT] = cmp_ref_out & I_MON_EN[dfa_pkg::MON_REF_OUT];
    ana_live[dfa_pkg::AN_REG]     = cmp_reg & I_MON_EN[dfa_pkg::MON_REG];
    ana_live[dfa_pkg::AN_RAIL]    = cmp_rail & I_MON_EN[dfa_pkg::MON_RAIL];
  end

  // digital sticky flags; slew and unrefreshed follow their live level
  logic [dfa_pkg::DG_W-1:0] dig_q;
  logic [dfa_pkg::DG_W-1:0] dig_d;
  logic [dfa_pkg::DG_W-1:0] self_clear;
  assign self_clear = (14'h0001 << dfa_pkg::DG_CAL_UNREF) | (14'h0001 << dfa_pkg::DG_SLEW_BUSY);
  assign dig_d = (sticky(dig_q, dig_live, I_DIG_CLR) & ~self_clear) | (dig_live & self_clear);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dig_q <= dfa_pkg::DG_RESET_VAL;
    end else begin
      dig_q <= dig_d;
    end
  end

  // analog sticky flags, write one to clear
  logic [dfa_pkg::AN_W-1:0] ana_q;
  logic [dfa_pkg::AN_W-1:0] ana_d;
  assign ana_d = (ana_q & ~I_ANA_CLR) | ana_live;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ana_q <= dfa_pkg::AN_RESET_VAL;
    end else begin
      ana_q <= ana_d;
    end
  end

  // alarm merge from the next flag values
  logic [dfa_pkg::DG_W-1:0] dig_alarm_src;
  logic [dfa_pkg::AN_W-1:0] ana_alarm_src;
  logic                     alarm_d;
  always_comb begin
    dig_alarm_src = dig_d & ~DG_NO_ALARM;
    dig_alarm_src = dig_alarm_src & ~(I_DIG_MASK & DG_MASKABLE);
    if (I_QUIET) begin
      dig_alarm_src[dfa_pkg::DG_SCLK_CNT] = 1'b0;
    end
    ana_alarm_src = ana_d & ~(I_ANA_MASK & AN_MASKABLE);
    alarm_d = (|dig_alarm_src) | (|ana_alarm_src);
  end

  // open-drain pin and its mirror, all from one flop set
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ALARM_N_OUT  <= 1'b0;
      O_ALARM_N_OE_N <= 1'b1;
      O_ALARM_MIRROR <= 1'b0;
    end else begin
      O_ALARM_N_OUT  <= 1'b0;
      O_ALARM_N_OE_N <= ~alarm_d;
      O_ALARM_MIRROR <= alarm_d;
    end
  end

  // flag readback and live summaries
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DIG_FLAGS   <= dfa_pkg::DG_RESET_VAL;
      O_ANA_FLAGS   <= dfa_pkg::AN_RESET_VAL;
      O_DIG_SUMMARY <= 1'b1;
      O_ANA_SUMMARY <= 1'b0;
      O_WDT_SUMMARY <= 1'b0;
    end else begin
      O_DIG_FLAGS   <= dig_d;
      O_ANA_FLAGS   <= ana_d;
      O_DIG_SUMMARY <= |(dig_d & ~(14'h0001 << dfa_pkg::DG_SLEW_BUSY));
      O_ANA_SUMMARY <= |ana_d;
      O_WDT_SUMMARY <= dig_d[dfa_pkg::DG_WDT];
    end
  end

  // monitor converter: entering the now mode or a rising key edge in the key and auto modes starts a conversion, result captured after fixed time
  dfa_pkg::dfa_conv_e      st_q;
  logic [dfa_pkg::CNT_W-1:0] cnt_q;
  logic                    key_q;
  logic                    key_rise;
  logic                    start;
  dfa_pkg::dfa_mode_e      mode;
  logic [dfa_pkg::MODE_W-1:0] mode_prev_q;
  assign mode     = dfa_pkg::dfa_mode_e'(I_CONV_MODE);
  assign key_rise = I_CONV_KEY & ~key_q;
  always_comb begin
    start = 1'b0;
    unique case (mode)
      dfa_pkg::DFA_MODE_NOW:     start = (mode_prev_q != I_CONV_MODE);
      dfa_pkg::DFA_MODE_KEY_ONE: start = key_rise;
      dfa_pkg::DFA_MODE_KEY_SEQ: start = key_rise;
      dfa_pkg::DFA_MODE_AUTO:    start = key_rise;
      default:                   start = 1'b0;
    endcase
  end

  // converter state
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q        <= dfa_pkg::DFA_ST_IDLE;
      cnt_q       <= '0;
      key_q       <= 1'b0;
      mode_prev_q <= '0;
    end else begin
      key_q       <= I_CONV_KEY;
      mode_prev_q <= I_CONV_MODE;
      unique case (st_q)
        dfa_pkg::DFA_ST_IDLE: begin
          if (start && !sel_reserved(I_CONV_SEL)) begin
            st_q  <= dfa_pkg::DFA_ST_CONV;
            cnt_q <= dfa_pkg::CNT_W'(dfa_pkg::CONV_CYCLES - 1);
          end
        end
        dfa_pkg::DFA_ST_CONV: begin
          if (cnt_q == '0) begin
            st_q <= dfa_pkg::DFA_ST_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        dfa_pkg::DFA_ST_DONE: begin
          st_q <= dfa_pkg::DFA_ST_IDLE;
        end
      endcase
    end
  end

  // converter outputs
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_MUX_SEL      <= dfa_pkg::SEL_TEMP_MAIN;
      O_MUX_RESERVED <= 1'b0;
      O_CONV_RESULT  <= '0;
      O_CONV_DONE    <= 1'b0;
    end else begin
      O_MUX_SEL      <= I_CONV_SEL;
      O_MUX_RESERVED <= sel_reserved(I_CONV_SEL);
      O_CONV_DONE    <= (st_q == dfa_pkg::DFA_ST_CONV) && (cnt_q == '0);
      if ((st_q == dfa_pkg::DFA_ST_CONV) && (cnt_q == '0)) begin
        O_CONV_RESULT <= I_CONV_SAMPLE;
      end
    end
  end
endmodule

// >>> dfa_top_chk.sv
// dfa_top_chk: port-level assertions for the diagnostic fault aggregator
// assumes: bound to dfa_top; one clock, asynchronous active-low reset
`timescale 1ns/100ps
module dfa_top_chk (
  input wire logic                        I_CLK,
  input wire logic                        I_RESETN,
  input wire logic [dfa_pkg::TEMP_W-1:0]  I_TEMP_MAIN,
  input wire logic [1:0]                  I_TRIP_SEL,
  input wire logic [dfa_pkg::MON_W-1:0]   I_MON_EN,
  input wire logic                        I_CMP_RAIL,
  input wire logic [dfa_pkg::AN_W-1:0]    I_ANA_CLR,
  input wire logic [dfa_pkg::DG_W-1:0]    I_DIG_MASK,
  input wire logic [dfa_pkg::AN_W-1:0]    I_ANA_MASK,
  input wire logic                        I_QUIET,
  input wire logic [dfa_pkg::SEL_W-1:0]   I_CONV_SEL,
  input wire logic                        O_ALARM_N_OUT,
  input wire logic                        O_ALARM_N_OE_N,
  input wire logic                        O_ALARM_MIRROR,
  input wire logic [dfa_pkg::DG_W-1:0]    O_DIG_FLAGS,
  input wire logic [dfa_pkg::AN_W-1:0]    O_ANA_FLAGS,
  input wire logic                        O_DIG_SUMMARY,
  input wire logic                        O_ANA_SUMMARY,
  input wire logic [dfa_pkg::SEL_W-1:0]   O_MUX_SEL,
  input wire logic                        O_MUX_RESERVED,
  input wire logic                        O_CONV_DONE
);
  logic [dfa_pkg::DG_W-1:0] eff_dig;
  logic [dfa_pkg::AN_W-1:0] eff_ana;
  logic [dfa_pkg::AN_W-1:0] held_ana;
  logic                     dig_or;
  logic                     ana_or;
  int                       lim;
  // flags allowed to pull the alarm after masks and quiet bit
  assign eff_dig  = O_DIG_FLAGS & 14'h1ff9 & ~(I_DIG_MASK & 14'h1ad1) & ~(14'(I_QUIET) << 10);
  assign eff_ana  = O_ANA_FLAGS & ~(I_ANA_MASK & 11'h07b);
  assign held_ana = O_ANA_FLAGS & ~I_ANA_CLR;
  assign dig_or   = |(O_DIG_FLAGS & 14'h1fff);
  assign ana_or   = |O_ANA_FLAGS;
  assign lim      = (I_TRIP_SEL == 2'h0) ? dfa_pkg::TRIP_142 : (I_TRIP_SEL == 2'h1) ? dfa_pkg::TRIP_127 :
                    (I_TRIP_SEL == 2'h2) ? dfa_pkg::TRIP_112 : dfa_pkg::TRIP_97;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // multi-cycle causes
  sequence s_rail_on;    (I_CMP_RAIL && I_MON_EN[dfa_pkg::MON_RAIL])[*3]; endsequence
  sequence s_hot_main;   (I_TEMP_MAIN > lim)[*3]; endsequence
  sequence s_alarm_due;  (eff_dig != 0 || eff_ana != 0)[*3]; endsequence
  sequence s_alarm_idle; (eff_dig == 0 && eff_ana == 0)[*3]; endsequence
  sequence s_dig_steady; dig_or[*2] or (!dig_or)[*2]; endsequence
  sequence s_ana_steady; ana_or[*2] or (!ana_or)[*2]; endsequence
  a_mirror_inverse:   assert property (O_ALARM_MIRROR == !O_ALARM_N_OE_N)
    else $error("alarm mirror not inverse of line");
  a_alarm_drain_only: assert property (!O_ALARM_N_OUT)
    else $error("alarm data not low");
  a_rail_flag_set:    assert property (s_rail_on |-> ##[0:1] O_ANA_FLAGS[dfa_pkg::AN_RAIL])
    else $error("rail flag not set");
  a_temp_flag_set:    assert property (s_hot_main |-> ##[0:1] O_ANA_FLAGS[dfa_pkg::AN_TEMP_MAIN])
    else $error("main die temperature flag not set");
  a_ana_sticky_hold:  assert property (1'b1 |=> ((O_ANA_FLAGS & $past(held_ana)) == $past(held_ana)))
    else $error("analog flag dropped without clear");
  a_dig_summary_or:   assert property (s_dig_steady |-> O_DIG_SUMMARY == dig_or)
    else $error("digital summary wrong");
  a_ana_summary_or:   assert property (s_ana_steady |-> O_ANA_SUMMARY == ana_or)
    else $error("analog summary wrong");
  a_alarm_raise:      assert property (s_alarm_due |-> !O_ALARM_N_OE_N)
    else $error("alarm not asserted");
  a_alarm_release:    assert property (s_alarm_idle |-> O_ALARM_N_OE_N)
    else $error("alarm asserted with no enabled fault");
  a_done_single:      assert property ($rose(O_CONV_DONE) |=> !O_CONV_DONE [*8])
    else $error("conversion done not a single pulse");
  a_mux_reserved:     assert property (O_MUX_SEL == I_CONV_SEL && O_MUX_SEL <= 5'h12 |->
    O_MUX_RESERVED == (O_MUX_SEL inside {5'h02, [5'h05:5'h0b]}))
    else $error("reserved select flag wrong");
endmodule

// >>> dfa_host_model.sv
// dfa_host_model: host side of the alarm line and the flag clears
// assumes: open-drain line with a pull-up; clears launched 2 ns after an edge
`timescale 1ns/100ps
module dfa_host_model (
  input  wire logic                    i_clk,
  input  wire logic                    i_alarm_out,
  input  wire logic                    i_alarm_oe_n,
  input  wire logic                    i_alarm_mirror,
  input  wire logic                    i_dig_sum,
  input  wire logic                    i_ana_sum,
  output logic [dfa_pkg::DG_W-1:0]     o_dig_clr,
  output logic [dfa_pkg::AN_W-1:0]     o_ana_clr,
  output logic                         o_line,
  output logic [1:0]                   o_cause
);
  // pull-up wins whenever the device releases the line
  assign o_line  = i_alarm_oe_n ? 1'b1 : i_alarm_out;
  // summaries read together with the mirror to name the source
  assign o_cause = i_alarm_mirror ? {i_ana_sum, i_dig_sum} : 2'h0;
  initial begin
    o_dig_clr = '0;
    o_ana_clr = '0;
  end
  // write-one-to-clear, one cycle wide
  task automatic clear(input logic [dfa_pkg::DG_W-1:0] d, input logic [dfa_pkg::AN_W-1:0] a);
    @(posedge i_clk);
    #2;
    o_dig_clr = d;
    o_ana_clr = a;
    @(posedge i_clk);
    #2;
    o_dig_clr = '0;
    o_ana_clr = '0;
  endtask
endmodule

// >>> test_dfa_top.sv
// test_dfa_top: self-checking bench for the diagnostic fault aggregator
// assumes: package, interface, design, host model and checker compiled before it
`timescale 1ns/100ps
module test_dfa_top;
  typedef struct {int at; logic [11:0] val;} dfa_note_s;
  logic                         clk, rst_n, int_en, quiet, key, c_ri, c_ro, c_rg, c_ra, al, rsv;
  logic                         a_out, oe_n, mirror, dig_sum, ana_sum, wdt_sum, mux_rsv, done, line;
  logic [dfa_pkg::TEMP_W-1:0]   t_main, t_dc;
  logic [1:0]                   trip, cause;
  logic [dfa_pkg::MON_W-1:0]    mon_en;
  logic [dfa_pkg::DG_W-1:0]     dig_f, dig_m, vd, dig_fl, dig_c;
  logic [dfa_pkg::AN_W-1:0]     ana_m, va, ana_fl, ana_c;
  logic [4:0]                   ana_f;
  logic [dfa_pkg::MODE_W-1:0]   mode;
  logic [dfa_pkg::SEL_W-1:0]    sel, mux_sel;
  logic [11:0]                  sample, res;
  logic [2:0]                   modes[4] = '{3'h4, 3'h5, 3'h2, 3'h3};
  int                           lims[4] = '{dfa_pkg::TRIP_142, dfa_pkg::TRIP_127, dfa_pkg::TRIP_112, dfa_pkg::TRIP_97};
  int                           seed, cyc, num_errors, comparisons;
  dfa_note_s                    exp_q[$];
  dfa_note_s                    note;
  dfa_top i_dut (.I_CLK(clk), .I_RESETN(rst_n), .I_TEMP_MAIN(t_main), .I_TEMP_DC(t_dc), .I_TRIP_SEL(trip),
    .I_MON_EN(mon_en), .I_INT_EN(int_en), .I_CMP_REF_IN(c_ri), .I_CMP_REF_OUT(c_ro), .I_CMP_REG(c_rg),
    .I_CMP_RAIL(c_ra), .I_DIG_FAULT(dig_f), .I_ANA_FAULT(ana_f), .I_DIG_CLR(dig_c), .I_ANA_CLR(ana_c),
    .I_DIG_MASK(dig_m), .I_ANA_MASK(ana_m), .I_QUIET(quiet), .I_CONV_MODE(mode), .I_CONV_SEL(sel),
    .I_CONV_KEY(key), .I_CONV_SAMPLE(sample), .O_ALARM_N_OUT(a_out), .O_ALARM_N_OE_N(oe_n),
    .O_ALARM_MIRROR(mirror), .O_DIG_FLAGS(dig_fl), .O_ANA_FLAGS(ana_fl), .O_DIG_SUMMARY(dig_sum),
    .O_ANA_SUMMARY(ana_sum), .O_WDT_SUMMARY(wdt_sum), .O_MUX_SEL(mux_sel), .O_MUX_RESERVED(mux_rsv),
    .O_CONV_RESULT(res), .O_CONV_DONE(done));
  dfa_host_model u_host (.i_clk(clk), .i_alarm_out(a_out), .i_alarm_oe_n(oe_n), .i_alarm_mirror(mirror),
    .i_dig_sum(dig_sum), .i_ana_sum(ana_sum), .o_dig_clr(dig_c), .o_ana_clr(ana_c), .o_line(line),
    .o_cause(cause));
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_conv(input logic [11:0] got, exp, input int at, want);
    comparisons++;
    if (got !== exp || at != want) begin
      num_errors++;
      $display("[FAIL] %0t conversion %h exp %h at %0d exp %0d", $time, got, exp, at, want);
    end
  endtask
  task automatic chk_stat(input logic [13:0] d, input logic [10:0] a, input logic x);
    chk(dig_fl, d, "digital flags");
    chk(ana_fl, a, "analog flags");
    chk(oe_n, !x, "alarm enable");
    chk(line, !x, "alarm line");
    chk(mirror, x, "alarm mirror");
    chk(dig_sum, |(d & 14'h1fff), "digital summary");
    chk(ana_sum, |a, "analog summary");
    chk(wdt_sum, d[dfa_pkg::DG_WDT], "watchdog summary");
    chk(cause, x ? {|a, |(d & 14'h1fff)} : 2'h0, "cause");
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // conversion results against the oldest note
  always @(negedge clk) begin
    if (rst_n && done === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[FAIL] %0t unexpected conversion done", $time);
      end else begin
        note = exp_q.pop_front();
        chk_conv(res, note.val, cyc, note.at);
      end
    end
  end
  // hang guard
  initial begin
    repeat (10000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end
  // main sequence
  initial begin
    seed = 32'hf51d_da38;
    {rst_n, int_en, quiet, key, c_ri, c_ro, c_rg, c_ra, trip, mon_en, dig_f, dig_m, ana_m, ana_f} = '0;
    {mode, sel, sample} = '0;
    t_main = 9'h019;
    t_dc = 9'h019;
    repeat (10) @(posedge clk);
    #2;
    chk_stat(14'h0004, 11'h000, 1'b0);
    rst_n = 1'b1;
    u_host.clear(14'h0004, 11'h000);
    tick(2);
    chk_stat(14'h0000, 11'h000, 1'b0);
    {c_ri, c_ro, c_rg, c_ra} = 4'hf;
    tick(5);
    chk_stat(14'h0000, 11'h000, 1'b0);
    mon_en = 4'hf;
    tick(5);
    chk_stat(14'h0000, 11'h680, 1'b1);
    int_en = 1'b1;
    tick(5);
    chk_stat(14'h0000, 11'h780, 1'b1);
    u_host.clear(14'h0000, 11'h780);
    tick(2);
    chk_stat(14'h0000, 11'h780, 1'b1);
    {c_ri, c_ro, c_rg, c_ra} = 4'h0;
    tick(4);
    u_host.clear(14'h0000, 11'h780);
    tick(2);
    chk_stat(14'h0000, 11'h000, 1'b0);
    mon_en = 4'h0;
    for (int k = 0; k < 23; k++) begin
      dig_m = 14'($random(seed));
      ana_m = 11'($random(seed));
      quiet = 1'($random(seed));
      trip = 2'(k - 19);
      vd = (k < 14) ? 14'h0001 << k : 14'h0000;
      va = (k < 14) ? 11'h000 : (k < 19) ? 11'h001 << (k - 14) : (k[0] ? 11'h040 : 11'h020);
      dig_f = vd;
      ana_f = va[4:0];
      if (k >= 19) begin
        t_main = 9'(lims[k-19] + int'(k[0]));
        t_dc = 9'(lims[k-19] + int'(!k[0]));
      end
      al = |(vd & 14'h1ff9 & ~(dig_m & 14'h1ad1) & ~(14'(quiet) << 10)) || |(va & ~(ana_m & 11'h07b));
      tick(5);
      chk_stat(vd, va, al);
      dig_f = '0;
      ana_f = '0;
      t_main = 9'h019;
      t_dc = 9'h019;
      tick(5);
      chk_stat(vd & 14'h1ffd, va, al);
      u_host.clear(vd, va);
      tick(2);
      chk_stat(14'h0000, 11'h000, 1'b0);
    end
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 19; c++) begin
        mode = 3'h0;
        key = 1'b0;
        sel = 5'(c);
        sample = 12'($random(seed));
        rsv = c inside {2, [5:11]};
        tick(2);
        mode = modes[m];
        if (m > 0) tick(1);
        key = (m > 0);
        if (!rsv) exp_q.push_back('{cyc + dfa_pkg::CONV_CYCLES + 1, sample});
        tick(6);
        key = 1'b0;
        tick(1);
        key = (m > 0);
        tick(14);
        chk(mux_rsv, rsv, "reserved select");
        chk(mux_sel, sel, "input select");
      end
    end
    tick(5);
    chk(16'(exp_q.size()), 16'h0000, "pending conversions");
    test_done;
  end
endmodule
bind dfa_top dfa_top_chk u_chk (.I_CLK, .I_RESETN, .I_TEMP_MAIN, .I_TRIP_SEL, .I_MON_EN, .I_CMP_RAIL, .I_ANA_CLR,
  .I_DIG_MASK, .I_ANA_MASK, .I_QUIET, .I_CONV_SEL, .O_ALARM_N_OUT, .O_ALARM_N_OE_N, .O_ALARM_MIRROR, .O_DIG_FLAGS,
  .O_ANA_FLAGS, .O_DIG_SUMMARY, .O_ANA_SUMMARY, .O_MUX_SEL, .O_MUX_RESERVED, .O_CONV_DONE);
